// [logic/spi_irq_mask_and_dma_regs.sv]
// SPI interrupt mask registers and the two data channel register sets
// Summary of operation
// RULE1 - Disable command: a one in bits 0..5 clears that mask bit.
// RULE2 - Mask state reads one bit per source, one means enabled, resets zero.
// RULE3 - A source whose mask bit is zero never requests an interrupt.
// RULE4 - Software loads the 32-bit receive pointer before a receive transfer.
// RULE5 - Software loads the 16-bit receive count; upper bits unused.
// RULE6 - No receive transfers while the receive count is zero.
// RULE7 - Nonzero receive count and receive full start a word move to memory.
// RULE8 - Software loads the 32-bit transmit pointer before transmit transfers.
// RULE9 - Software loads the 16-bit transmit count field.
// RULE10 - No transmit transfers while the transmit count is zero.
// RULE11 - Nonzero transmit count and transmit empty fetch next word.
// RULE12 - Enable command: a one sets that mask bit.
// RULE13 - Receive full sets on a new word, holds until the data is read.
// RULE14 - Receive end flag reads one while receive end signal is active.
// RULE15 - Transmit end flag reads one while transmit end signal is active.
// RULE16 - Each transfer moves a word, pointer plus four, count minus one.
// RULE17 - Interrupt is OR of each status flag ANDed with its mask bit.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spi_irq_mask_and_dma_regs
	import spi_chan_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial unit events and data
	input wire logic rx_word_loaded,
	input wire logic [15:0] rx_word,
	input wire logic rx_data_read,
	input wire logic transmit_empty_flag,
	input wire logic mode_fault_event,
	input wire logic overrun_event,
	output logic [15:0] tx_word,
	output logic tx_word_load,
	// Receive channel memory write port
	output logic rx_mem_req,
	output logic [31:0] rx_mem_addr,
	output logic [31:0] rx_mem_wdata,
	input wire logic rx_mem_ack,
	// Transmit channel memory read port
	output logic tx_mem_req,
	output logic [31:0] tx_mem_addr,
	input wire logic [31:0] tx_mem_rdata,
	input wire logic tx_mem_ack,
	// Status and interrupt
	output logic receive_full_flag,
	output logic irq
);
	import spi_chan_pkg::*;
	logic wr_en;
	logic rd_en;
	logic [NUM_SRC-1:0] mask;
	logic [NUM_SRC-1:0] sticky;
	logic [NUM_SRC-1:0] status;
	logic [NUM_SRC-1:0] event_in;
	logic [15:0] rx_hold;
	logic receive_end_flag;
	logic transmit_end_flag;
	logic [31:0] rx_address_field;
	logic [31:0] tx_address_field;
	logic [COUNT_WIDTH-1:0] rx_count_field;
	logic [COUNT_WIDTH-1:0] tx_count_field;
	logic rx_done;
	logic tx_done;
	logic rx_trigger;
	logic tx_trigger;
	logic mapped;
	logic [31:0] next_rdata;
	logic wr_irq_enable;
	logic wr_irq_disable;
	logic wr_rx_address;
	logic wr_rx_count;
	logic wr_tx_address;
	logic wr_tx_count;
	logic wr_status;
	logic rx_end_q;
	logic tx_end_q;

	// Read mux packs fixed field widths; refuse a package that breaks them
	generate
		if (NUM_SRC != 32'h6 || COUNT_WIDTH != 32'h10) begin : g_bad_layout
			$error("Source count or counter width unsupported");
		end
	endgenerate

	// Zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	// Read data is picked up in the setup cycle, not the access cycle
	assign rd_en = psel && !penable && !pwrite;

	// Write strobes, one register per access cycle
	always_comb begin
		wr_irq_enable = 1'b0;
		wr_irq_disable = 1'b0;
		wr_rx_address = 1'b0;
		wr_rx_count = 1'b0;
		wr_tx_address = 1'b0;
		wr_tx_count = 1'b0;
		wr_status = 1'b0;
		if (wr_en) begin
			if (paddr == OFF_IRQ_ENABLE_CMD) begin
				wr_irq_enable = 1'b1;
			end else if (paddr == OFF_IRQ_DISABLE_CMD) begin
				wr_irq_disable = 1'b1;
			end else if (paddr == OFF_RX_BUFFER_ADDRESS) begin
				wr_rx_address = 1'b1;
			end else if (paddr == OFF_RX_BUFFER_COUNT) begin
				wr_rx_count = 1'b1;
			end else if (paddr == OFF_TX_BUFFER_ADDRESS) begin
				wr_tx_address = 1'b1;
			end else if (paddr == OFF_TX_BUFFER_COUNT) begin
				wr_tx_count = 1'b1;
			end else if (paddr == OFF_IRQ_STATUS) begin
				wr_status = 1'b1;
			end
		end
	end

	// Receive data holding register and its full flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_hold <= 16'h0000;
		end else if (rx_word_loaded) begin
			rx_hold <= rx_word;
		end
	end

	// RULE13 full flag hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_full_flag <= 1'b0;
		end else if (rx_word_loaded) begin
			receive_full_flag <= 1'b1;
		end else if (rx_data_read || rx_done) begin
			receive_full_flag <= 1'b0;
		end
	end

	// RULE7 receive start
	assign rx_trigger = receive_full_flag;
	// RULE11 transmit start
	assign tx_trigger = transmit_empty_flag;

	// Receive channel; count gating lives inside the channel
	// RULE6 zero count idle
	spi_data_channel u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.load_address(wr_rx_address),
		.load_count(wr_rx_count),
		.wdata(pwdata),
		.trigger(rx_trigger),
		.mem_req(rx_mem_req),
		.mem_ack(rx_mem_ack),
		.mem_addr(rx_mem_addr),
		.address(rx_address_field),
		.count(rx_count_field),
		.end_of_transfer(receive_end_flag),
		.word_done(rx_done)
	);
	assign rx_mem_wdata = {16'h0000, rx_hold};

	// Transmit channel
	// RULE10 zero count idle
	spi_data_channel u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.load_address(wr_tx_address),
		.load_count(wr_tx_count),
		.wdata(pwdata),
		.trigger(tx_trigger),
		.mem_req(tx_mem_req),
		.mem_ack(tx_mem_ack),
		.mem_addr(tx_mem_addr),
		.address(tx_address_field),
		.count(tx_count_field),
		.end_of_transfer(transmit_end_flag),
		.word_done(tx_done)
	);

	// Fetched word goes to the transmit data register as a one-cycle load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_word <= 16'h0000;
			tx_word_load <= 1'b0;
		end else begin
			tx_word_load <= tx_done;
			if (tx_done) begin
				tx_word <= tx_mem_rdata[15:0];
			end
		end
	end

	// Event sources per bit; end flags are rising edges of the end signals
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_end_q <= 1'b1;
			tx_end_q <= 1'b1;
		end else begin
			rx_end_q <= receive_end_flag;
			tx_end_q <= transmit_end_flag;
		end
	end
	assign event_in[POS_RECEIVE_FULL] = rx_word_loaded;
	assign event_in[POS_TRANSMIT_EMPTY] = 1'b0;
	assign event_in[POS_MODE_FAULT] = mode_fault_event;
	assign event_in[POS_OVERRUN] = overrun_event;
	assign event_in[POS_RECEIVE_END] = receive_end_flag && !rx_end_q;
	assign event_in[POS_TRANSMIT_END] = transmit_end_flag && !tx_end_q;

	// Sticky status per source; a set in the clear cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sticky[gi] <= 1'b0;
				end else if (event_in[gi]) begin
					sticky[gi] <= 1'b1;
				end else if (wr_status && pwdata[gi]) begin
					sticky[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Full and empty flags read live; end flags read the live signal ORed with the sticky edge bit
	assign status[POS_RECEIVE_FULL] = receive_full_flag;
	assign status[POS_TRANSMIT_EMPTY] = transmit_empty_flag;
	assign status[POS_MODE_FAULT] = sticky[POS_MODE_FAULT];
	assign status[POS_OVERRUN] = sticky[POS_OVERRUN];
	// RULE14 receive end level
	assign status[POS_RECEIVE_END] = receive_end_flag || sticky[POS_RECEIVE_END];
	// RULE15 transmit end level
	assign status[POS_TRANSMIT_END] = transmit_end_flag || sticky[POS_TRANSMIT_END];

	// Mask: enable sets, disable clears; disable wins if both in one write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= RESET_MASK;
		// RULE1 disable clears
		end else if (wr_irq_disable) begin
			mask <= mask & ~pwdata[NUM_SRC-1:0];
		// RULE12 enable sets
		end else if (wr_irq_enable) begin
			mask <= mask | pwdata[NUM_SRC-1:0];
		end
	end

	// RULE3 masked sources blocked
	// RULE17 OR of gated flags
	assign irq = |(status & mask);

	// Address decode and read mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		mapped = 1'b1;
		if (paddr == OFF_IRQ_ENABLE_CMD || paddr == OFF_IRQ_DISABLE_CMD) begin
			next_rdata = 32'h0000_0000;
		// RULE2 mask readback
		end else if (paddr == OFF_IRQ_ENABLE_STATE) begin
			next_rdata = {26'h0000000, mask};
		// RULE4 receive pointer
		end else if (paddr == OFF_RX_BUFFER_ADDRESS) begin
			next_rdata = rx_address_field;
		// RULE5 receive count
		end else if (paddr == OFF_RX_BUFFER_COUNT) begin
			next_rdata = {16'h0000, rx_count_field};
		// RULE8 transmit pointer
		end else if (paddr == OFF_TX_BUFFER_ADDRESS) begin
			next_rdata = tx_address_field;
		// RULE9 transmit count
		end else if (paddr == OFF_TX_BUFFER_COUNT) begin
			next_rdata = {16'h0000, tx_count_field};
		end else if (paddr == OFF_IRQ_STATUS) begin
			next_rdata = {26'h0000000, status};
		end else begin
			mapped = 1'b0;
		end
	end

	// Read data registered in the setup cycle so it is stable in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= next_rdata;
		end
	end

	// Unmapped address answers with an error in the access cycle
	assign pslverr = psel && penable && !mapped;
endmodule : spi_irq_mask_and_dma_regs
`default_nettype wire

// [logic/spi_chan_pkg.sv]
// Register map, field layout and constants of the SPI mask and channel bank
package spi_chan_pkg;
	localparam logic [7:0] OFF_IRQ_ENABLE_CMD = 8'h14;
	localparam logic [7:0] OFF_IRQ_DISABLE_CMD = 8'h18;
	localparam logic [7:0] OFF_IRQ_ENABLE_STATE = 8'h1c;
	localparam logic [7:0] OFF_RX_BUFFER_ADDRESS = 8'h20;
	localparam logic [7:0] OFF_RX_BUFFER_COUNT = 8'h24;
	localparam logic [7:0] OFF_TX_BUFFER_ADDRESS = 8'h28;
	localparam logic [7:0] OFF_TX_BUFFER_COUNT = 8'h2c;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
	localparam int NUM_SRC = 6;
	localparam int POS_RECEIVE_FULL = 0;
	localparam int POS_TRANSMIT_EMPTY = 1;
	localparam int POS_MODE_FAULT = 2;
	localparam int POS_OVERRUN = 3;
	localparam int POS_RECEIVE_END = 4;
	localparam int POS_TRANSMIT_END = 5;
	localparam int COUNT_WIDTH = 16;
	localparam logic [5:0] RESET_MASK = 6'h00;
	localparam logic [31:0] RESET_ADDRESS = 32'h0000_0000;
	localparam logic [15:0] RESET_COUNT = 16'h0000;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	typedef enum logic [1:0] {CH_IDLE, CH_REQ, CH_DONE} chan_state_t;
endpackage : spi_chan_pkg

// [logic/spi_data_channel.sv]
// One data channel: pointer, counter and one-word memory transfer sequencer
`timescale 1ns/1ps
`default_nettype none
module spi_data_channel
	import spi_chan_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Software loads
	input wire logic load_address,
	input wire logic load_count,
	input wire logic [31:0] wdata,
	// Request from the serial side
	input wire logic trigger,
	// Memory port
	output logic mem_req,
	input wire logic mem_ack,
	output logic [31:0] mem_addr,
	// State
	output logic [31:0] address,
	output logic [spi_chan_pkg::COUNT_WIDTH-1:0] count,
	output logic end_of_transfer,
	output logic word_done
);
	import spi_chan_pkg::*;
	chan_state_t state;
	logic [31:0] next_address;

	assign next_address = address + WORD_BYTES;
	assign mem_req = (state == CH_REQ);
	assign mem_addr = address;
	// RULE16 end signal
	assign end_of_transfer = (count == RESET_COUNT);
	assign word_done = (state == CH_REQ) && mem_ack;

	// Sequencer; DONE gives the flag source a cycle to drop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CH_IDLE;
		end else begin
			case (state)
				CH_IDLE: begin
					if (trigger && !end_of_transfer) begin
						state <= CH_REQ;
					end
				end
				CH_REQ: begin
					if (mem_ack) begin
						state <= CH_DONE;
					end
				end
				default: begin
					state <= CH_IDLE;
				end
			endcase
		end
	end

	// Pointer; a software load wins over a step in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			address <= RESET_ADDRESS;
		end else if (load_address) begin
			address <= wdata;
		// RULE16 pointer advance
		end else if (word_done) begin
			address <= next_address;
		end
	end

	// Counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= RESET_COUNT;
		end else if (load_count) begin
			count <= wdata[COUNT_WIDTH-1:0];
		// RULE16 counter decrement
		end else if (word_done) begin
			count <= count - 16'h0001;
		end
	end
endmodule : spi_data_channel
`default_nettype wire

// [verif/spi_mem_model.sv]
// Memory model answering both channel ports after a set delay
`timescale 1ns/1ps
`default_nettype none
module spi_mem_model (
	// Clock and answer delay in cycles
	input wire logic pclk,
	input wire logic [3:0] delay,
	// Receive channel writes
	input wire logic rx_mem_req,
	input wire logic [31:0] rx_mem_addr,
	input wire logic [31:0] rx_mem_wdata,
	output logic rx_mem_ack = 1'b0,
	// Transmit channel reads
	input wire logic tx_mem_req,
	input wire logic [31:0] tx_mem_addr,
	output logic [31:0] tx_mem_rdata = 32'h0,
	output logic tx_mem_ack = 1'b0,
	// Last write seen
	output logic [31:0] last_addr = 32'h0,
	output logic [31:0] last_data = 32'h0
);
	logic [3:0] rx_wait = 4'h0;
	logic [3:0] tx_wait = 4'h0;
	// Write side answers once the delay has run out
	always_ff @(posedge pclk) begin
		rx_mem_ack <= 1'b0;
		if (rx_mem_req && !rx_mem_ack) begin
			rx_wait <= rx_wait + 4'h1;
			if (rx_wait >= delay) begin
				rx_mem_ack <= 1'b1;
				rx_wait <= 4'h0;
				last_addr <= rx_mem_addr;
				last_data <= rx_mem_wdata;
			end
		end
	end
	// Read data toggles outside an answer, so stale data never matches
	always_ff @(posedge pclk) begin
		tx_mem_ack <= 1'b0;
		tx_mem_rdata <= ~tx_mem_rdata;
		if (tx_mem_req && !tx_mem_ack) begin
			tx_wait <= tx_wait + 4'h1;
			if (tx_wait >= delay) begin
				tx_mem_ack <= 1'b1;
				tx_wait <= 4'h0;
				tx_mem_rdata <= {16'h0000, tx_mem_addr[15:0] ^ 16'h5a5a};
			end
		end
	end
endmodule : spi_mem_model
`default_nettype wire

// [verif/spi_irq_mask_and_dma_regs_assertions.sv]
// Port assertions for the SPI mask and channel bank
`timescale 1ns/1ps
`default_nettype none
module spi_regs_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Receive side and channels
	input wire logic rx_word_loaded,
	input wire logic rx_data_read,
	input wire logic receive_full_flag,
	input wire logic rx_mem_req,
	input wire logic rx_mem_ack,
	input wire logic [31:0] rx_mem_addr,
	input wire logic tx_mem_req,
	input wire logic tx_mem_ack,
	input wire logic tx_word_load
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Full flag set and clear
	full_set_a: assert property (rx_word_loaded |=> receive_full_flag)
		else $error("full flag not set");
	full_clear_a: assert property (
		rx_data_read && !rx_word_loaded |=> !receive_full_flag)
		else $error("full flag not cleared");
	// Receive channel requests
	rx_cause_a: assert property (
		$rose(rx_mem_req) |-> $past(receive_full_flag))
		else $error("receive request without full word");
	rx_hold_a: assert property (
		rx_mem_req && !rx_mem_ack |=> rx_mem_req && $stable(rx_mem_addr))
		else $error("receive request dropped");
	rx_step_a: assert property (
		rx_mem_req && rx_mem_ack |=>
		!rx_mem_req && rx_mem_addr == $past(rx_mem_addr) + 32'h4)
		else $error("receive pointer step wrong");
	rx_drain_a: assert property (
		rx_mem_req && rx_mem_ack && !rx_word_loaded |=> !receive_full_flag)
		else $error("full flag kept after move");
	// Transmit channel requests
	tx_hold_a: assert property (
		tx_mem_req && !tx_mem_ack |=> tx_mem_req)
		else $error("transmit request dropped");
	tx_load_a: assert property (
		tx_mem_req && tx_mem_ack |=> tx_word_load ##1 !tx_word_load)
		else $error("transmit word load wrong");
endmodule : spi_regs_checker
bind spi_irq_mask_and_dma_regs spi_regs_checker spi_regs_checker_i (
	.pclk, .presetn, .rx_word_loaded, .rx_data_read, .receive_full_flag,
	.rx_mem_req, .rx_mem_ack, .rx_mem_addr, .tx_mem_req, .tx_mem_ack,
	.tx_word_load);
`default_nettype wire

// [verif/spi_irq_mask_and_dma_regs_bench.sv]
// Self-checking bench for the SPI mask and channel bank
`timescale 1ns/1ps
`default_nettype none
module spi_irq_mask_and_dma_regs_bench;
	import spi_chan_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic rx_word_loaded = 1'b0;
	logic rx_data_read = 1'b0;
	logic transmit_empty_flag = 1'b0;
	logic mode_fault_event = 1'b0;
	logic overrun_event = 1'b0;
	logic [15:0] rx_word = 16'h0;
	logic [3:0] delay = 4'h0;
	logic [31:0] prdata, q, rx_mem_addr, rx_mem_wdata, tx_mem_addr;
	logic [31:0] tx_mem_rdata, last_addr, last_data;
	logic [15:0] tx_word;
	logic pready, pslverr, err, tx_word_load, rx_mem_req, rx_mem_ack;
	logic tx_mem_req, tx_mem_ack, receive_full_flag, irq;
	int fails = 0;
	int compares = 0;
	spi_irq_mask_and_dma_regs spi_irq_mask_and_dma_regs_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_word_loaded, .rx_word, .rx_data_read, .transmit_empty_flag,
		.mode_fault_event, .overrun_event, .tx_word, .tx_word_load,
		.rx_mem_req, .rx_mem_addr, .rx_mem_wdata, .rx_mem_ack, .tx_mem_req,
		.tx_mem_addr, .tx_mem_rdata, .tx_mem_ack, .receive_full_flag, .irq);
	spi_mem_model spi_mem_model_i (.pclk, .delay, .rx_mem_req, .rx_mem_addr,
		.rx_mem_wdata, .rx_mem_ack, .tx_mem_req, .tx_mem_addr, .tx_mem_rdata,
		.tx_mem_ack, .last_addr, .last_data);
	// Clock
	initial forever #4 pclk = ~pclk;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One bus transfer, then an idle cycle so no strobe is set twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask : rd
	task automatic pulse(input int k);
		rx_word_loaded <= (k == 0);
		rx_data_read <= (k == 1);
		mode_fault_event <= (k == 2);
		overrun_event <= (k == 3);
		@(posedge pclk);
		{rx_word_loaded, rx_data_read, mode_fault_event, overrun_event} <= 4'h0;
		@(posedge pclk);
	endtask : pulse
	task automatic await(input bit tx);
		repeat (40) begin
			@(posedge pclk);
			if ((tx ? tx_word_load : rx_mem_ack) === 1'b1)
				return;
		end
		fails++;
		$display("Error handshake expected 1 seen 0");
	endtask : await
	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	// Watchdog well beyond the expected run
	initial begin
		#80000;
		fails++;
		wrap_up();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 5; i++) rd(8'h1c + 8'(4 * i), 32'h0);
		rd(OFF_IRQ_STATUS, 32'h30);
		apb(1'b1, OFF_IRQ_ENABLE_CMD, 32'h3f);
		rd(OFF_IRQ_ENABLE_STATE, 32'h3f);
		apb(1'b1, OFF_IRQ_DISABLE_CMD, 32'h05);
		rd(OFF_IRQ_ENABLE_STATE, 32'h3a);
		apb(1'b1, OFF_IRQ_ENABLE_STATE, 32'h0);
		rd(OFF_IRQ_ENABLE_STATE, 32'h3a);
		apb(1'b1, OFF_IRQ_DISABLE_CMD, 32'h3f);
		rd(OFF_IRQ_ENABLE_STATE, 32'h0);
		rd(8'h40, 32'h0);
		chk("pslverr", 1, err);
		// Events only interrupt while enabled
		for (int i = 2; i < 4; i++) begin
			pulse(i);
			chk("irq masked", 0, irq);
			apb(1'b1, OFF_IRQ_ENABLE_CMD, 32'(1 << i));
			chk("irq", 1, irq);
			apb(1'b1, OFF_IRQ_STATUS, 32'(1 << i));
			chk("irq cleared", 0, irq);
			apb(1'b1, OFF_IRQ_DISABLE_CMD, 32'(1 << i));
		end
		apb(1'b1, OFF_RX_BUFFER_ADDRESS, 32'h100);
		apb(1'b1, OFF_RX_BUFFER_COUNT, 32'hffff_0000);
		rd(OFF_RX_BUFFER_ADDRESS, 32'h100);
		rd(OFF_RX_BUFFER_COUNT, 32'h0);
		apb(1'b1, OFF_TX_BUFFER_ADDRESS, 32'h200);
		apb(1'b1, OFF_TX_BUFFER_COUNT, 32'h1);
		rd(OFF_TX_BUFFER_ADDRESS, 32'h200);
		rd(OFF_TX_BUFFER_COUNT, 32'h1);
		// Full word with zero count stays put
		pulse(0);
		chk("full", 1, receive_full_flag);
		repeat (6) begin
			@(posedge pclk);
			chk("rx req", 0, rx_mem_req);
		end
		pulse(1);
		chk("full", 0, receive_full_flag);
		// Two words to memory with a slow answer
		delay <= 4'h3;
		apb(1'b1, OFF_RX_BUFFER_COUNT, 32'h2);
		for (int w = 0; w < 2; w++) begin
			rx_word <= 16'h1234 + 16'(w);
			pulse(0);
			await(1'b0);
			chk("rx addr", 32'h100 + 32'(4 * w), last_addr);
			chk("rx data", 32'h1234 + 32'(w), last_data);
		end
		rd(OFF_RX_BUFFER_ADDRESS, 32'h108);
		rd(OFF_RX_BUFFER_COUNT, 32'h0);
		apb(1'b0, OFF_IRQ_STATUS, 32'h0);
		chk("receive end", 1, q[4]);
		// One word fetched, then none with the count spent
		delay <= 4'h0;
		transmit_empty_flag <= 1'b1;
		await(1'b1);
		chk("tx word", 32'h585a, 32'(tx_word));
		repeat (6) begin
			@(posedge pclk);
			chk("tx req", 0, tx_mem_req);
		end
		rd(OFF_TX_BUFFER_ADDRESS, 32'h204);
		rd(OFF_TX_BUFFER_COUNT, 32'h0);
		apb(1'b0, OFF_IRQ_STATUS, 32'h0);
		chk("transmit end", 1, q[5]);
		// Live empty flag interrupts only while enabled
		apb(1'b1, OFF_IRQ_ENABLE_CMD, 32'h02);
		chk("irq empty", 1, irq);
		apb(1'b1, OFF_IRQ_DISABLE_CMD, 32'h02);
		chk("irq empty masked", 0, irq);
		wrap_up();
	end
endmodule : spi_irq_mask_and_dma_regs_bench
`default_nettype wire
